//--- tcic_pkg.sv
// Purpose: Shared constants for the 16-bit timer counter and input capture unit.
// Assumes: An 8-bit I/O bus with a 4-bit location index.
// Notes: Location indices and bit positions are shared by both ends.
package tcic_pkg;
    // I/O location indices.
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_CNT_LO = 4'h2;
    localparam logic [3:0] ADDR_CNT_HI = 4'h3;
    localparam logic [3:0] ADDR_CAP_LO = 4'h4;
    localparam logic [3:0] ADDR_CAP_HI = 4'h5;
    localparam logic [3:0] ADDR_FLAGS = 4'h6;
    localparam logic [3:0] ADDR_MASK = 4'h7;
    localparam logic [3:0] ADDR_CMP_CS = 4'h8;
    // Field positions.
    localparam int CTRL_B_NOISE_BIT = 7;
    localparam int CTRL_B_EDGE_BIT = 6;
    localparam int CTRL_B_WGM_LSB = 3;
    localparam int FLAG_CAP_BIT = 5;
    localparam int FLAG_OVF_BIT = 2;
    localparam int CMP_OUT_BIT = 5;
    localparam int CMP_CAP_SEL_BIT = 2;
    // Values after reset.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // Counter extremes and fixed tops.
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    // Clock select codes.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Noise filter depth in system clock cycles.
    localparam int NOISE_SAMPLES = 4;
    localparam int PRESCALE_WIDTH = 10;
endpackage

//--- tcic_if.sv
// Purpose: Byte-wide I/O bus and interrupt lines between the CPU and the timer.
// Assumes: All signals are synchronous to one system clock.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
interface tcic_if;
    logic [3:0] io_addr;
    logic [7:0] io_wdata;
    logic io_we;
    logic io_re;
    logic [7:0] io_rdata;
    logic cap_irq;
    logic ovf_irq;
    logic cap_ack;
    logic ovf_ack;
    modport dev (input io_addr, input io_wdata, input io_we, input io_re, output io_rdata,
                 output cap_irq, output ovf_irq, input cap_ack, input ovf_ack);
    modport host (output io_addr, output io_wdata, output io_we, output io_re, input io_rdata,
                  input cap_irq, input ovf_irq, output cap_ack, output ovf_ack);
endinterface

//--- tcic_timer.sv
// Purpose: Counter unit and input capture unit of a 16-bit timer on an 8-bit bus.
// Assumes: Pins are synchronous to sys_clk; the CPU keeps wide accesses atomic.
// Notes: Output compare units are absent, so tops taken from them read as 0xffff.
//
// Operation
// - Shared upper byte may be reused, atomically.
// - Clock-select zero stops the counter.
// - 16-bit counter counts up, down, or clears.
// - Upper-byte location reaches the holding register.
// - Lower read latches upper; lower write loads.
// - Counter accessible whether or not running.
// - CPU write beats count or clear.
// - Four-bit mode field sets the sequence.
// - Overflow flag set per mode, raises interrupt.
// - Selected edge copies counter into capture.
// - Capture flag set with copy; interrupt enable.
// - Capture flag cleared by service or one.
// - Capture lower read first latches upper.
// - Capture writable only in capture-top modes.
// - Comparator select bit chooses trigger source.
// - Filter output changes after four equal samples.
// - Filter enable bit; four cycles added.
// - Capture inputs off in capture-top modes.
// - Software-driven pin captures like external.
// - New capture overwrites unread capture value.
// - Edge reversal and flag clear are software's.
// - Bottom is 0x0000, maximum 0xffff.
// - Lower write loads both bytes together.
`timescale 1ns/1ps
module tcic_timer import tcic_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // CPU side
    tcic_if.dev bus,
    // Pins
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic ext_clk_pin
);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decoding.

    function automatic logic icr_is_top(input logic [3:0] m);
        icr_is_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
    endfunction

    function automatic logic dual_slope(input logic [3:0] m);
        dual_slope = (m == 4'h1) || (m == 4'h2) || (m == 4'h3) || (m >= 4'h8 && m <= 4'hb);
    endfunction

    function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] icr);
        case (m[1:0])
            2'h1: mode_top = TOP_8BIT;
            2'h2: mode_top = TOP_9BIT;
            2'h3: mode_top = TOP_10BIT;
            default: mode_top = COUNT_MAX;
        endcase
        if (m[3] || m == 4'h4) begin
            mode_top = icr_is_top(m) ? icr : COUNT_MAX;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [15:0] count_value_reg;
    logic [15:0] capture_value_reg;
    logic [7:0] temp_reg;
    logic capture_flag_reg;
    logic overflow_flag_reg;
    logic capture_irq_enable_reg;
    logic overflow_irq_enable_reg;
    logic comparator_capture_select_reg;
    logic count_down_reg;
    logic [PRESCALE_WIDTH-1:0] prescale_reg;
    logic ext_prev_reg;
    logic src_sample_reg;
    logic [NOISE_SAMPLES-2:0] noise_hist_reg;
    logic filtered_reg;
    logic edge_prev_reg;
    logic [7:0] rdata_reg;
    logic cap_irq_reg;
    logic ovf_irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding and selection.

    wire logic [2:0] clock_select_field = ctrl_b_reg[2:0];
    wire logic [3:0] waveform_mode_field = {ctrl_b_reg[CTRL_B_WGM_LSB+1:CTRL_B_WGM_LSB], ctrl_a_reg[1:0]};
    wire logic noise_filter_enable = ctrl_b_reg[CTRL_B_NOISE_BIT];
    wire logic capture_rising = ctrl_b_reg[CTRL_B_EDGE_BIT];
    wire logic [15:0] top_value = mode_top(waveform_mode_field, capture_value_reg);
    wire logic icr_top_mode = icr_is_top(waveform_mode_field);
    wire logic is_dual = dual_slope(waveform_mode_field);
    wire logic ctc_mode = (waveform_mode_field == 4'h4) || (waveform_mode_field == 4'hc);

    wire logic wr_ctrl_a = bus.io_we && bus.io_addr == ADDR_CTRL_A;
    wire logic wr_ctrl_b = bus.io_we && bus.io_addr == ADDR_CTRL_B;
    wire logic wr_cnt_lo = bus.io_we && bus.io_addr == ADDR_CNT_LO;
    wire logic wr_cap_lo = bus.io_we && bus.io_addr == ADDR_CAP_LO && icr_top_mode;
    wire logic wr_hi = bus.io_we && (bus.io_addr == ADDR_CNT_HI || bus.io_addr == ADDR_CAP_HI);
    wire logic wr_flags = bus.io_we && bus.io_addr == ADDR_FLAGS;
    wire logic wr_mask = bus.io_we && bus.io_addr == ADDR_MASK;
    wire logic wr_cmp = bus.io_we && bus.io_addr == ADDR_CMP_CS;
    wire logic rd_cnt_lo = bus.io_re && bus.io_addr == ADDR_CNT_LO;
    wire logic rd_cap_lo = bus.io_re && bus.io_addr == ADDR_CAP_LO;

    // Timer clock: a one-cycle enable from the prescaler or the external pin.
    wire logic ext_fall = ext_prev_reg && !ext_clk_pin;
    wire logic ext_rise = !ext_prev_reg && ext_clk_pin;
    logic timer_clock;
    always_comb begin
        case (clock_select_field)
            CS_DIV1: timer_clock = 1'b1;
            CS_DIV8: timer_clock = &prescale_reg[2:0];
            CS_DIV64: timer_clock = &prescale_reg[5:0];
            CS_DIV256: timer_clock = &prescale_reg[7:0];
            CS_DIV1024: timer_clock = &prescale_reg[9:0];
            CS_EXT_FALL: timer_clock = ext_fall;
            CS_EXT_RISE: timer_clock = ext_rise;
            default: timer_clock = 1'b0;
        endcase
    end

    // Counter sequence.
    wire logic at_top = count_value_reg == top_value;
    wire logic at_bottom = count_value_reg == COUNT_BOTTOM;
    wire logic at_max = count_value_reg == COUNT_MAX;
    wire logic turn_down = is_dual && !count_down_reg && at_top;
    wire logic turn_up = is_dual && count_down_reg && at_bottom;
    wire logic going_down = is_dual && (turn_down || (count_down_reg && !turn_up));
    wire logic clear_now = !is_dual && (at_top || at_max);
    logic [15:0] count_step;
    always_comb begin
        if (clear_now) begin
            count_step = COUNT_BOTTOM;
        end else if (going_down) begin
            count_step = count_value_reg - 16'h0001;
        end else begin
            count_step = count_value_reg + 16'h0001;
        end
    end
    // Normal and CTC flag at MAX, fast PWM at TOP, dual slope at BOTTOM.
    wire logic ovf_event = timer_clock && (is_dual ? turn_up : (ctc_mode ? at_max : at_top));

    // Capture source, filter and edge detector.
    wire logic capture_source = comparator_capture_select_reg ? comparator_output : capture_pin;
    wire logic hist_all_high = &{noise_hist_reg, src_sample_reg};
    wire logic hist_all_low = ~|{noise_hist_reg, src_sample_reg};
    wire logic filter_in = noise_filter_enable ? filtered_reg : src_sample_reg;
    wire logic edge_seen = capture_rising ? (filter_in && !edge_prev_reg) : (!filter_in && edge_prev_reg);
    wire logic capture_event = edge_seen && !icr_top_mode;

    wire logic cap_clear = bus.cap_ack || (wr_flags && bus.io_wdata[FLAG_CAP_BIT]);
    wire logic ovf_clear = bus.ovf_ack || (wr_flags && bus.io_wdata[FLAG_OVF_BIT]);

    logic [7:0] rdata_next;
    always_comb begin
        case (bus.io_addr)
            ADDR_CTRL_A: rdata_next = ctrl_a_reg;
            ADDR_CTRL_B: rdata_next = ctrl_b_reg;
            ADDR_CNT_LO: rdata_next = count_value_reg[7:0];
            ADDR_CAP_LO: rdata_next = capture_value_reg[7:0];
            ADDR_CNT_HI, ADDR_CAP_HI: rdata_next = temp_reg;
            ADDR_FLAGS: rdata_next = 8'(capture_flag_reg) << FLAG_CAP_BIT | 8'(overflow_flag_reg) << FLAG_OVF_BIT;
            ADDR_MASK: rdata_next = 8'(capture_irq_enable_reg) << FLAG_CAP_BIT
                                    | 8'(overflow_irq_enable_reg) << FLAG_OVF_BIT;
            ADDR_CMP_CS: rdata_next = 8'(comparator_output) << CMP_OUT_BIT
                                      | 8'(comparator_capture_select_reg) << CMP_CAP_SEL_BIT;
            default: rdata_next = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control and bus registers.

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_a_reg <= CTRL_RESET;
            ctrl_b_reg <= CTRL_RESET;
            capture_irq_enable_reg <= 1'b0;
            overflow_irq_enable_reg <= 1'b0;
            comparator_capture_select_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            if (wr_ctrl_a) ctrl_a_reg <= bus.io_wdata;
            if (wr_ctrl_b) ctrl_b_reg <= bus.io_wdata;
            if (wr_mask) capture_irq_enable_reg <= bus.io_wdata[FLAG_CAP_BIT];
            if (wr_mask) overflow_irq_enable_reg <= bus.io_wdata[FLAG_OVF_BIT];
            if (wr_cmp) comparator_capture_select_reg <= bus.io_wdata[CMP_CAP_SEL_BIT];
            if (bus.io_re) rdata_reg <= rdata_next;
        end
    end

    // One holding register serves every wide location, so an interrupt handler that
    // touches another wide register between two byte accesses corrupts the first.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            temp_reg <= 8'h00;
        end else if (wr_hi) begin
            temp_reg <= bus.io_wdata;
        end else if (rd_cnt_lo) begin
            temp_reg <= count_value_reg[15:8];
        end else if (rd_cap_lo) begin
            temp_reg <= capture_value_reg[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter and prescaler.

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_value_reg <= COUNT_RESET;
            count_down_reg <= 1'b0;
            prescale_reg <= '0;
            ext_prev_reg <= 1'b0;
        end else begin
            prescale_reg <= prescale_reg + 1'b1;
            ext_prev_reg <= ext_clk_pin;
            if (wr_cnt_lo) begin
                count_value_reg <= {temp_reg, bus.io_wdata};
            end else if (timer_clock) begin
                count_value_reg <= count_step;
            end
            if (!is_dual) begin
                count_down_reg <= 1'b0;
            end else if (timer_clock) begin
                count_down_reg <= going_down;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input capture.

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            src_sample_reg <= 1'b0;
            noise_hist_reg <= '0;
            filtered_reg <= 1'b0;
            edge_prev_reg <= 1'b0;
            capture_value_reg <= COUNT_RESET;
        end else begin
            src_sample_reg <= capture_source;
            noise_hist_reg <= {noise_hist_reg[NOISE_SAMPLES-3:0], src_sample_reg};
            if (hist_all_high) filtered_reg <= 1'b1;
            if (hist_all_low) filtered_reg <= 1'b0;
            edge_prev_reg <= filter_in;
            if (wr_cap_lo) begin
                capture_value_reg <= {temp_reg, bus.io_wdata};
            end else if (capture_event) begin
                capture_value_reg <= count_value_reg;
            end
        end
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            capture_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
            cap_irq_reg <= 1'b0;
            ovf_irq_reg <= 1'b0;
        end else begin
            if (capture_event) begin
                capture_flag_reg <= 1'b1;
            end else if (cap_clear) begin
                capture_flag_reg <= 1'b0;
            end
            if (ovf_event) begin
                overflow_flag_reg <= 1'b1;
            end else if (ovf_clear) begin
                overflow_flag_reg <= 1'b0;
            end
            cap_irq_reg <= (capture_event || (capture_flag_reg && !cap_clear)) && capture_irq_enable_reg;
            ovf_irq_reg <= (ovf_event || (overflow_flag_reg && !ovf_clear)) && overflow_irq_enable_reg;
        end
    end

    assign bus.io_rdata = rdata_reg;
    assign bus.cap_irq = cap_irq_reg;
    assign bus.ovf_irq = ovf_irq_reg;

endmodule

//--- tcic_host.sv
// Purpose: CPU-side bus engine that turns byte and word commands into I/O cycles.
// Assumes: One command at a time; the timer answers reads one cycle later.
// Notes: A wide write sends the upper byte first; a wide read takes the lower first.
`timescale 1ns/1ps
module tcic_host import tcic_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Timer side
    tcic_if.host bus,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_wide,
    input wire logic [3:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    // Interrupt service
    input wire logic cap_service,
    input wire logic ovf_service,
    output logic cap_pending,
    output logic ovf_pending
);

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_WR_HI = 7'h02,
        ST_WR_LO = 7'h04,
        ST_RD_LO = 7'h08,
        ST_RD_LO_W = 7'h10,
        ST_RD_HI = 7'h20,
        ST_RD_HI_W = 7'h40
    } tcic_state_e;

    tcic_state_e state_reg;
    logic [3:0] addr_reg;
    logic [7:0] wdata_reg;
    logic we_reg;
    logic re_reg;
    logic [3:0] lo_addr_reg;
    logic [7:0] lo_data_reg;
    logic wide_reg;
    logic ack_cap_reg;
    logic ack_ovf_reg;

    wire logic take = cmd_valid && cmd_ready && state_reg == ST_IDLE;
    wire logic [3:0] hi_addr = cmd_addr + 4'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // The sequence runs to its end without interleaving, which keeps it atomic.

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            addr_reg <= 4'h0;
            wdata_reg <= 8'h00;
            we_reg <= 1'b0;
            re_reg <= 1'b0;
            lo_addr_reg <= 4'h0;
            lo_data_reg <= 8'h00;
            wide_reg <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (take) begin
                        cmd_ready <= 1'b0;
                        lo_addr_reg <= cmd_addr;
                        wide_reg <= cmd_wide;
                        lo_data_reg <= cmd_wdata[7:0];
                        if (cmd_write && cmd_wide) begin
                            addr_reg <= hi_addr;
                            wdata_reg <= cmd_wdata[15:8];
                            we_reg <= 1'b1;
                            state_reg <= ST_WR_HI;
                        end else if (cmd_write) begin
                            addr_reg <= cmd_addr;
                            wdata_reg <= cmd_wdata[7:0];
                            we_reg <= 1'b1;
                            state_reg <= ST_WR_LO;
                        end else begin
                            addr_reg <= cmd_addr;
                            re_reg <= 1'b1;
                            state_reg <= ST_RD_LO;
                        end
                    end
                end
                ST_WR_HI: begin
                    addr_reg <= lo_addr_reg;
                    wdata_reg <= lo_data_reg;
                    state_reg <= ST_WR_LO;
                end
                ST_WR_LO: begin
                    we_reg <= 1'b0;
                    rsp_valid <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_RD_LO: begin
                    re_reg <= 1'b0;
                    state_reg <= ST_RD_LO_W;
                end
                ST_RD_LO_W: begin
                    rsp_data <= {8'h00, bus.io_rdata};
                    if (wide_reg) begin
                        addr_reg <= lo_addr_reg + 4'h1;
                        re_reg <= 1'b1;
                        state_reg <= ST_RD_HI;
                    end else begin
                        rsp_valid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RD_HI: begin
                    re_reg <= 1'b0;
                    state_reg <= ST_RD_HI_W;
                end
                ST_RD_HI_W: begin
                    rsp_data[15:8] <= bus.io_rdata;
                    rsp_valid <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    we_reg <= 1'b0;
                    re_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Servicing an interrupt sends a one-cycle acknowledge that clears the flag.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_cap_reg <= 1'b0;
            ack_ovf_reg <= 1'b0;
            cap_pending <= 1'b0;
            ovf_pending <= 1'b0;
        end else begin
            ack_cap_reg <= cap_service && !ack_cap_reg;
            ack_ovf_reg <= ovf_service && !ack_ovf_reg;
            cap_pending <= bus.cap_irq;
            ovf_pending <= bus.ovf_irq;
        end
    end

    assign bus.io_addr = addr_reg;
    assign bus.io_wdata = wdata_reg;
    assign bus.io_we = we_reg;
    assign bus.io_re = re_reg;
    assign bus.cap_ack = ack_cap_reg;
    assign bus.ovf_ack = ack_ovf_reg;

endmodule

//--- tcic_timer_properties.sv
// Purpose: Bus and interrupt properties of the timer interface.
// Assumes: One clock; synchronous active-high reset.
// Notes: Shadows track only what the bus alone settles.
`timescale 1ns/1ps
module tcic_timer_properties import tcic_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Bus and interrupts
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [7:0] io_rdata,
    input wire logic cap_irq,
    input wire logic ovf_irq,
    input wire logic cap_ack,
    input wire logic ovf_ack
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    logic [7:0] tmp_reg;
    logic [7:0] mask_reg;
    logic [15:0] cnt_reg;
    logic tmp_ok_reg;
    logic cnt_ok_reg;
    logic stop_reg;
    wire wr_hi = io_we && (io_addr == ADDR_CNT_HI || io_addr == ADDR_CAP_HI);
    wire rd_hi = io_re && (io_addr == ADDR_CNT_HI || io_addr == ADDR_CAP_HI);
    wire wr_cnt = io_we && io_addr == ADDR_CNT_LO;
    wire rd_cnt = io_re && io_addr == ADDR_CNT_LO;
    wire wr_b = io_we && io_addr == ADDR_CTRL_B;
    wire cap_en = mask_reg[FLAG_CAP_BIT];
    wire ovf_en = mask_reg[FLAG_OVF_BIT];
    // The count shadow is trusted only while the counter is known to stand still.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tmp_ok_reg <= 1'b0;
            cnt_ok_reg <= 1'b1;
            stop_reg <= 1'b1;
            mask_reg <= 8'h00;
            cnt_reg <= COUNT_RESET;
        end else begin
            if (wr_hi) tmp_reg <= io_wdata;
            tmp_ok_reg <= wr_hi | (rd_cnt ? cnt_ok_reg : tmp_ok_reg & ~(io_re && io_addr == ADDR_CAP_LO));
            if (rd_cnt) tmp_reg <= cnt_reg[15:8];
            if (wr_cnt) cnt_reg <= {tmp_reg, io_wdata};
            if (wr_b) stop_reg <= io_wdata[2:0] == CS_STOP;
            cnt_ok_reg <= (wr_b && io_wdata[2:0] != CS_STOP) ? 1'b0 : (wr_cnt ? tmp_ok_reg & stop_reg : cnt_ok_reg);
            if (io_we && io_addr == ADDR_MASK) mask_reg <= io_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////
    AST_RST_QUIET: assert property ($fell(sys_rst) |-> io_rdata == 8'h00 && !cap_irq && !ovf_irq)
        else $error("outputs not quiet after reset");
    AST_UNMAPPED: assert property (io_re && io_addr > ADDR_CMP_CS |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!io_re |=> $stable(io_rdata))
        else $error("read data moved without a read");
    AST_HOLD_READ: assert property (rd_hi && tmp_ok_reg |=> io_rdata == $past(tmp_reg))
        else $error("upper location did not return holding byte");
    AST_CNT_READ: assert property (rd_cnt && cnt_ok_reg |=> io_rdata == cnt_reg[7:0])
        else $error("stopped count lower byte wrong");
    AST_CAP_MASK: assert property (!cap_en && !$past(cap_en) |-> !cap_irq)
        else $error("capture request while disabled");
    AST_OVF_MASK: assert property (!ovf_en && !$past(ovf_en) |-> !ovf_irq)
        else $error("overflow request while disabled");
    AST_MASK_READ: assert property (io_re && io_addr == ADDR_MASK |=> (io_rdata & 8'h24) == ($past(mask_reg) & 8'h24))
        else $error("enable bits read back wrong");
    COV_CNT: cover property (rd_cnt && cnt_ok_reg);
    COV_CAP: cover property ($rose(cap_irq));
    COV_OVF: cover property ($rose(ovf_irq));
endmodule

//--- timer16_counter_input_capture_tb.sv
// Purpose: Drives the host command port against the timer and checks results.
// Assumes: Inputs change at the falling clock edge.
// Notes: Narrow reads compare the low byte only.
`timescale 1ns/1ps
module timer16_counter_input_capture_tb import tcic_pkg::*;;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pin = 1'b0, cmp = 1'b0, ext = 1'b0, cv = 1'b0, cw = 1'b0, cwide = 1'b0, csv = 1'b0;
    logic [3:0] ca = 4'h0;
    logic [15:0] cd = 16'h0000;
    logic [15:0] v, rsp_data;
    logic cmd_ready, rsp_valid, cap_pending, ovf_pending;
    logic [31:0] e, q[$];
    int err_count = 0, n_tests = 0;
    int seed = 32'hb1410619;
    tcic_if bus_if();
    tcic_timer tcic_timer_i(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if), .capture_pin(pin),
        .comparator_output(cmp), .ext_clk_pin(ext));
    tcic_host tcic_host_i(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if), .cmd_valid(cv), .cmd_write(cw),
        .cmd_wide(cwide), .cmd_addr(ca), .cmd_wdata(cd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .cap_service(csv), .ovf_service(1'b0), .cap_pending(cap_pending),
        .ovf_pending(ovf_pending));
    tcic_timer_properties tcic_timer_properties_i(.sys_clk(sys_clk), .sys_rst(sys_rst),
        .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata), .io_we(bus_if.io_we), .io_re(bus_if.io_re),
        .io_rdata(bus_if.io_rdata), .cap_irq(bus_if.cap_irq), .ovf_irq(bus_if.ovf_irq),
        .cap_ack(bus_if.cap_ack), .ovf_ack(bus_if.ovf_ack));
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("errors %0d tests %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // For a read, d is the expected value; it is queued for the response watcher.
    task automatic cmd(input logic w, input logic wide, input logic [3:0] a, input logic [15:0] d);
        int n;
        @(negedge sys_clk);
        for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
        cv = 1'b1;
        cw = w;
        cwide = wide;
        ca = a;
        cd = d;
        q.push_back(w ? 32'h0 : {(wide ? 16'hffff : 16'h00ff), d});
        @(negedge sys_clk);
        cv = 1'b0;
        for (n = 0; n < 50 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
        if (rsp_valid !== 1'b1) err_count++;
    endtask
    task automatic capt(input logic src, input logic [15:0] cv16, input int hold, input logic early, input logic hit);
        cmd(1, 1, ADDR_CNT_LO, cv16);
        cmd(1, 0, ADDR_FLAGS, 16'h0020);
        repeat (3) @(negedge sys_clk);
        chk({15'h0, cap_pending}, 16'h0000);
        if (src) cmp = 1'b1;
        else pin = 1'b1;
        repeat (hold) @(negedge sys_clk);
        chk({15'h0, cap_pending}, {15'h0, early});
        pin = 1'b0;
        cmp = 1'b0;
        repeat (12) @(negedge sys_clk);
        chk({15'h0, cap_pending}, {15'h0, hit});
    endtask
    ////////////////////////////////////////////////////////////////
    initial forever #2 sys_clk = ~sys_clk;
    always @(negedge sys_clk) ext <= 1'($random(seed));
    always @(negedge sys_clk) begin
        if (rsp_valid === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            if (e[31:16] != 16'h0) chk(rsp_data & e[31:16], e[15:0]);
        end
    end
    initial begin
        #80000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        cmd(1, 0, ADDR_CTRL_B, 16'h0040);
        repeat (3) begin
            v = 16'($random(seed));
            cmd(1, 1, ADDR_CNT_LO, v);
            cmd(0, 1, ADDR_CNT_LO, v);
        end
        cmd(1, 0, ADDR_CNT_HI, 16'h00a5);
        cmd(0, 0, ADDR_CNT_HI, 16'h00a5);
        cmd(0, 0, 4'hf, 16'h0000);
        cmd(1, 0, ADDR_MASK, 16'h0020);
        capt(0, 16'h1111, 3, 1, 1);
        capt(0, 16'h2222, 12, 1, 1);
        cmd(0, 1, ADDR_CAP_LO, 16'h2222);
        cmd(1, 0, ADDR_CTRL_B, 16'h00c0);
        capt(0, 16'h3333, 2, 0, 0);
        capt(0, 16'h4444, 7, 1, 1);
        cmd(0, 1, ADDR_CAP_LO, 16'h4444);
        cmd(1, 0, ADDR_CTRL_B, 16'h0000);
        capt(0, 16'h5555, 12, 0, 1);
        cmd(1, 0, ADDR_CMP_CS, 16'h0004);
        capt(1, 16'h6666, 12, 0, 1);
        cmd(0, 1, ADDR_CAP_LO, 16'h6666);
        cmd(1, 1, ADDR_CAP_LO, 16'h1234);
        cmd(0, 1, ADDR_CAP_LO, 16'h6666);
        csv = 1'b1;
        @(negedge sys_clk);
        csv = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({15'h0, cap_pending}, 16'h0000);
        capt(0, 16'h7777, 12, 0, 0);
        cmd(1, 0, ADDR_MASK, 16'h0024);
        cmd(1, 1, ADDR_CNT_LO, 16'hfff0);
        cmd(1, 0, ADDR_CTRL_B, 16'h0001);
        repeat (40) @(negedge sys_clk);
        chk({15'h0, ovf_pending}, 16'h0001);
        give_verdict();
    end
endmodule
